// ### logic/port_regs.svh
/*
 * Register map, field positions and reset values of the port block:
 * the bank of pin direction registers and the two-pin port registers.
 * Assumes it is included by bare name from the package and the testbench files; the guard skips repeats.
 */
`ifndef PORT_REGS_SVH
`define PORT_REGS_SVH

// direction bank: printed indices, byte address is four times the index
`define DIR_IDX_P0 20'hFFF20
`define DIR_IDX_P1 20'hFFF21
`define DIR_IDX_P2 20'hFFF22
`define DIR_IDX_P3 20'hFFF23
`define DIR_IDX_P4 20'hFFF24
`define DIR_IDX_P5 20'hFFF25
`define DIR_IDX_P6 20'hFFF26
`define DIR_IDX_P7 20'hFFF27
`define DIR_IDX_P8 20'hFFF28
`define DIR_IDX_P11 20'hFFF2B
`define DIR_IDX_P12 20'hFFF2C
`define DIR_IDX_P13 20'hFFF2D
`define DIR_IDX_P14 20'hFFF2E
`define DIR_IDX_P15 20'hFFF2F
// port data, pull-up and alternate-function control, indices of our own
`define IDX_P3_DATA 20'hFFF30
`define IDX_P3_PULLUP 20'hFFF31
`define IDX_ALT_CTRL 20'hFFF32

// reset values
`define DIR_RESET 8'hFF
`define DIR13_RESET 8'hFE
`define DATA_RESET 8'h00
`define PULLUP_RESET 8'h00
`define ALT_RESET 8'h00

// fixed bits of direction registers: mask of fixed bits and their value
`define FIX_MASK_P0 8'h80
`define FIX_VAL_P0 8'h80
`define FIX_MASK_P3 8'hFC
`define FIX_VAL_P3 8'hFC
`define FIX_MASK_P11 8'hFC
`define FIX_VAL_P11 8'hFC
`define FIX_MASK_P12 8'hFE
`define FIX_VAL_P12 8'hFE
`define FIX_MASK_P13 8'hFD
`define FIX_VAL_P13 8'hFC
`define FIX_MASK_P14 8'hC0
`define FIX_VAL_P14 8'hC0
`define FIX_MASK_NONE 8'h00

// alternate control fields
`define ALT_TOUT_LEVEL 0
`define ALT_TOUT_EN 1
`define ALT_RCLK_EN 2

`endif

// ### logic/port_pkg.sv
/*
 * Types shared by the port block.
 * Assumes port_regs.svh is available on the include path.
 */
package port_pkg;
  `include "port_regs.svh"
  typedef enum logic [1:0] {ph_idle, ph_write, ph_read} bus_phase_t;
  localparam int unsigned num_dir_regs = 14;
endpackage

// ### logic/two_bit_port.sv
/*
 * Two-pin general-purpose port with output latch, direction and pull-up
 * select, the bank of direction registers, and the alternate functions
 * of the pins, behind an AHB-Lite slave with zero wait states.
 * Assumes a single 200 MHz clock, pins arriving asynchronously.
 */
// Chosen here: register access over AHB-Lite.
// How it works
// RULE_01 - two bidirectional pins, each with an output latch
// RULE_02 - one direction bit per pin, independently selectable
// RULE_03 - pull-up select bit per pin, active only in input mode
// RULE_04 - reset leaves both pins input with drivers off
// RULE_05 - pins also serve interrupt inputs, timer I/O, correction clock
// RULE_06 - software keeps timer ch3 level and enable zero for plain pin 1
// RULE_07 - software keeps correction clock enable zero for plain pin 0
// RULE_08 - direction bit zero means output, driver drives the latch
// RULE_09 - direction bit one means input, driver off
// RULE_10 - software writes fixed bits of direction registers as documented
// RULE_11 - data read returns pin level for inputs, latch for outputs
`timescale 1ns/1ps
module two_bit_port
  import port_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [1:0] port3_pin_in,
  output logic [1:0] port3_pin_out,
  output logic [1:0] port3_pin_oe,
  output logic [1:0] port3_pullup_en,
  input wire logic timer_ch3_out,
  input wire logic rtc_correction_clock,
  output logic timer_ch3_input,
  output logic ext_irq_input_a,
  output logic ext_irq_input_b,
  output logic [7:0] port0_direction_out
);

  // direction bank storage, one byte per printed register
  logic [7:0] dir_bank [num_dir_regs];
  logic [7:0] port3_data_latch;
  logic [7:0] port3_pullup_select;
  logic [7:0] alt_ctrl;
  bus_phase_t phase;
  logic [4:0] phase_sel;
  logic [1:0] pin_meta;
  logic [1:0] pin_sync;

  // table lookups: word address to bank slot, slot to fixed-bit pattern
  function automatic logic [4:0] slot_of(input logic [29:0] widx);
    case (widx[19:0])
      `DIR_IDX_P0: slot_of = 5'h00;
      `DIR_IDX_P1: slot_of = 5'h01;
      `DIR_IDX_P2: slot_of = 5'h02;
      `DIR_IDX_P3: slot_of = 5'h03;
      `DIR_IDX_P4: slot_of = 5'h04;
      `DIR_IDX_P5: slot_of = 5'h05;
      `DIR_IDX_P6: slot_of = 5'h06;
      `DIR_IDX_P7: slot_of = 5'h07;
      `DIR_IDX_P8: slot_of = 5'h08;
      `DIR_IDX_P11: slot_of = 5'h09;
      `DIR_IDX_P12: slot_of = 5'h0A;
      `DIR_IDX_P13: slot_of = 5'h0B;
      `DIR_IDX_P14: slot_of = 5'h0C;
      `DIR_IDX_P15: slot_of = 5'h0D;
      `IDX_P3_DATA: slot_of = 5'h10;
      `IDX_P3_PULLUP: slot_of = 5'h11;
      `IDX_ALT_CTRL: slot_of = 5'h12;
      default: slot_of = 5'h1F;
    endcase
    if (widx[29:20] != 10'h000)
      slot_of = 5'h1F;
  endfunction

  function automatic logic [15:0] fixed_of(input logic [4:0] slot);
    case (slot)
      5'h00: fixed_of = {`FIX_MASK_P0, `FIX_VAL_P0};
      5'h03: fixed_of = {`FIX_MASK_P3, `FIX_VAL_P3};
      5'h09: fixed_of = {`FIX_MASK_P11, `FIX_VAL_P11};
      5'h0A: fixed_of = {`FIX_MASK_P12, `FIX_VAL_P12};
      5'h0B: fixed_of = {`FIX_MASK_P13, `FIX_VAL_P13};
      5'h0C: fixed_of = {`FIX_MASK_P14, `FIX_VAL_P14};
      default: fixed_of = {`FIX_MASK_NONE, `FIX_MASK_NONE};
    endcase
  endfunction

  function automatic logic [7:0] dir_reset_of(input int idx);
    dir_reset_of = (idx == 11) ? `DIR13_RESET : `DIR_RESET;
  endfunction

  // bus decode of the address phase
  wire addr_valid = hsel & hready & htrans[1];
  wire [4:0] addr_slot = slot_of(haddr[31:2]);

  // the slave never stalls and always answers OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // address phase capture; data phase follows one cycle later
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      phase <= ph_idle;
      phase_sel <= 5'h1F;
    end
    else
    begin
      phase <= !addr_valid ? ph_idle : (hwrite ? ph_write : ph_read);
      phase_sel <= addr_slot;
    end
  end

  wire do_write = (phase == ph_write);
  wire do_read = (phase == ph_read);
  wire [15:0] fix = fixed_of(phase_sel);
  // fixed bits are forced so software cannot break the unimplemented pins
  wire [7:0] wr_byte = (hwdata[7:0] & ~fix[15:8]) | fix[7:0]; // [RULE_10]

  // direction bank; reset puts every pin in input mode except bit 0 of P13
  for (genvar g = 0; g < num_dir_regs; g++)
  begin : g_dir
    always_ff @(posedge hclk or negedge hresetn)
    begin
      if (!hresetn)
        dir_bank[g] <= dir_reset_of(g); // [RULE_04]
      else if (do_write && phase_sel == 5'(g))
        dir_bank[g] <= wr_byte; // [RULE_02]
    end
  end

  // port latch, pull-up select and alternate-function control
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      port3_data_latch <= `DATA_RESET;
      port3_pullup_select <= `PULLUP_RESET;
      alt_ctrl <= `ALT_RESET;
    end
    else if (do_write)
    begin
      case (phase_sel)
        5'h10: port3_data_latch <= {6'h00, hwdata[1:0]}; // [RULE_01]
        5'h11: port3_pullup_select <= {6'h00, hwdata[1:0]}; // [RULE_03]
        5'h12: alt_ctrl <= {5'h00, hwdata[2:0]};
        default: ;
      endcase
    end
  end

  // two-stage synchroniser on the pin inputs
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pin_meta <= 2'h0;
      pin_sync <= 2'h0;
    end
    else
    begin
      pin_meta <= port3_pin_in;
      pin_sync <= pin_meta;
    end
  end

  // direction and alternate selection per pin
  wire [1:0] pin_is_input = dir_bank[3][1:0];
  wire tout_active = alt_ctrl[`ALT_TOUT_EN];
  wire rclk_active = alt_ctrl[`ALT_RCLK_EN];
  // the timer output level only matters while its enable is set
  wire pin1_alt_val = alt_ctrl[`ALT_TOUT_LEVEL] ? 1'b1 : timer_ch3_out;
  wire [1:0] drive_val =
    {tout_active ? pin1_alt_val : port3_data_latch[1],
     rclk_active ? rtc_correction_clock : port3_data_latch[0]}; // [RULE_05]

  // zero drives, one floats; the alternate functions ride on output mode
  assign port3_pin_oe = ~pin_is_input; // [RULE_08] [RULE_09]
  assign port3_pin_out = drive_val & port3_pin_oe; // [RULE_01]
  assign port3_pullup_en =
    pin_is_input & port3_pullup_select[1:0]; // [RULE_03]

  // alternate inputs always see the synchronised pin level
  assign ext_irq_input_a = pin_sync[0]; // [RULE_05]
  assign ext_irq_input_b = pin_sync[1];
  assign timer_ch3_input = pin_sync[1];
  assign port0_direction_out = dir_bank[0];

  // read mux: input pins show the pin, output pins show the latch
  wire [1:0] data_view = (pin_is_input & pin_sync) |
    (~pin_is_input & port3_data_latch[1:0]); // [RULE_11]
  wire [7:0] rd_byte =
    (phase_sel < 5'(num_dir_regs)) ? dir_bank[phase_sel[3:0]] :
    (phase_sel == 5'h10) ? {6'h00, data_view} :
    (phase_sel == 5'h11) ? port3_pullup_select :
    (phase_sel == 5'h12) ? alt_ctrl : 8'h00;

  // read data is combinational from registers during the data phase
  assign hrdata = do_read ? {24'h000000, rd_byte} : 32'h00000000;

  // the slot decode holds at most sixteen direction registers
  if (num_dir_regs > 16)
  begin : g_size_check
    $error("direction bank too large for slot decode");
  end

endmodule

// ### testbench/port_props.sv
/* checker of two_bit_port pins and bus answers
   bound to the design, sees only its top ports */
`timescale 1ns/1ps
`include "port_regs.svh"
module port_props
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic [1:0] port3_pin_in,
  input wire logic [1:0] port3_pin_out,
  input wire logic [1:0] port3_pin_oe,
  input wire logic [1:0] port3_pullup_en,
  input wire logic ext_irq_input_a,
  input wire logic [7:0] port0_direction_out
);
  // a transfer is taken when selected, ready and non-idle
  wire take = hsel && hreadyout && htrans[1];
  wire dir3 = haddr == {10'h0, `DIR_IDX_P3, 2'h0};
  logic rd_ph, wr_ph, wr_dn;
  logic [1:0] wd;
  logic [1:0] up;
  // follow each read into its data phase and each P3 direction write one edge past it
  always_ff @(posedge hclk)
  begin
    rd_ph <= take && !hwrite;
    wr_ph <= take && hwrite && dir3;
    wr_dn <= wr_ph;
    wd <= hwdata[1:0];
  end
  // edges since reset, so the synchroniser check skips stale history
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      up <= 2'h0;
    else if (up != 2'h3)
      up <= up + 2'h1;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_reset_off: assert property (disable iff (1'b0)
    !hresetn |-> port3_pin_oe == 2'h0 && port3_pullup_en == 2'h0)
    else $error("pins active in reset");
  a_dir_reset: assert property (disable iff (1'b0)
    !hresetn |-> port0_direction_out == 8'hFF) else $error("dir reset");
  a_dir_write: assert property (
    wr_dn |-> port3_pin_oe == ~wd) else $error("direction not taken");
  a_off_low: assert property (
    (port3_pin_out & ~port3_pin_oe) == 2'h0) else $error("drive when off");
  a_pull_input: assert property (
    (port3_pullup_en & port3_pin_oe) == 2'h0) else $error("pull on output");
  a_irq_sync: assert property (
    up == 2'h3 |-> ext_irq_input_a == $past(port3_pin_in[0], 2))
    else $error("interrupt input lag");
  a_idle_read: assert property (
    !rd_ph |-> hrdata == 32'h0) else $error("read data outside phase");
  a_read_byte: assert property (
    rd_ph |-> hrdata[31:8] == 24'h0 && hreadyout) else $error("read word");
  a_dir0_fixed: assert property (
    port0_direction_out[7]) else $error("fixed bit lost");
  c_dir_write: cover property (wr_dn);
  c_read: cover property (rd_ph);
  c_pull: cover property (port3_pullup_en != 2'h0);
endmodule
bind two_bit_port port_props chk_u (.*);

// ### testbench/pin_model.sv
/* board side of port 3: resolves each pin level
   assumes the bench drives ext_d and ext_e for outside parts */
`timescale 1ns/1ps
module pin_model
(
  input wire logic hclk,
  input wire logic [1:0] pin_out,
  input wire logic [1:0] pin_oe,
  input wire logic [1:0] pull_en,
  input wire logic [1:0] ext_d,
  input wire logic [1:0] ext_e,
  output logic [1:0] pin
);
  logic tog = 1'b0;
  // a floating pin wanders, so it never passes for a clean level
  always @(posedge hclk)
    tog <= ~tog;
  // port drive wins, then outside drive, then pull-up or wander
  assign pin = (pin_oe & pin_out) | (~pin_oe & ext_e & ext_d)
    | (~pin_oe & ~ext_e & (pull_en | {tog, ~tog}));
endmodule

// ### testbench/tb.sv
/* self-checking bench of two_bit_port
   assumes pin_model stands in for the board */
`timescale 1ns/1ps
`include "port_regs.svh"
module tb;
  typedef struct {logic [19:0] i; logic [7:0] d; logic [7:0] e;} row_t;
  row_t rows [5] = '{'{`DIR_IDX_P0, 8'h00, 8'h80},
    '{`DIR_IDX_P1, 8'h5A, 8'h5A}, '{`DIR_IDX_P13, 8'h00, 8'hFC},
    '{`DIR_IDX_P3, 8'h01, 8'hFD}, '{20'hFFF3F, 8'hFF, 8'h00}};
  logic hclk = 1'b0, hresetn = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic tmr = 1'b0, rclk = 1'b0, hreadyout, hresp, tci, irqa, irqb;
  logic [1:0] htrans = 2'h0, ext_d = 2'h0, ext_e = 2'h0;
  logic [1:0] pin, pout, poe, pue;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
  logic [7:0] p0d;
  int fails = 0, n_checks = 0, cyc = 0, i;
  always #2.5 hclk = ~hclk;
  two_bit_port dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .port3_pin_in(pin),
    .port3_pin_out(pout), .port3_pin_oe(poe), .port3_pullup_en(pue),
    .timer_ch3_out(tmr), .rtc_correction_clock(rclk),
    .timer_ch3_input(tci), .ext_irq_input_a(irqa),
    .ext_irq_input_b(irqb), .port0_direction_out(p0d));
  pin_model pm_u (.hclk(hclk), .pin_out(pout), .pin_oe(poe),
    .pull_en(pue), .ext_d(ext_d), .ext_e(ext_e), .pin(pin));
  function logic [31:0] ba(input logic [19:0] x);
    ba = {10'h0, x, 2'h0};
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: %h not %h", $time, got, exp);
    end
  endtask
  task summarize;
    $display("%0d checks, %0d mismatches", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // one single transfer; each phase is held until hready is seen
  task xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    // read data is taken while it stands, before the edge that ends it
    do
    begin
      @(negedge hclk);
      q = hrdata;
      @(posedge hclk);
    end
    while (hreadyout !== 1'b1);
  endtask
  task rdc(input logic [19:0] x, input logic [7:0] e);
    xfer(ba(x), 1'b0, 32'h0);
    chk(q, {24'h0, e});
  endtask
  // a hang is cut short well past the expected run
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      fails++;
      summarize();
    end
  end
  initial
  begin
    // a real falling edge so the asynchronous reset takes hold at once
    hresetn <= 1'b0;
    repeat (6) @(posedge hclk);
    chk(poe, 32'h0);
    hresetn <= 1'b1;
    rdc(`DIR_IDX_P3, 8'hFF);
    rdc(`DIR_IDX_P13, 8'hFE);
    $display("reset test done");
    for (i = 0; i < 5; i++)
    begin
      xfer(ba(rows[i].i), 1'b1, {24'h0, rows[i].d});
      rdc(rows[i].i, rows[i].e);
    end
    $display("table test done");
    // pin0 drives its latch while pin1 reads the outside level
    xfer(ba(`DIR_IDX_P3), 1'b1, 32'hFE);
    xfer(ba(`IDX_P3_DATA), 1'b1, 32'h1);
    ext_e <= 2'h2;
    ext_d <= 2'h2;
    repeat (3) @(posedge hclk);
    chk({poe, pout}, 32'h5);
    rdc(`IDX_P3_DATA, 8'h03);
    chk({tci, irqb, irqa}, 32'h7);
    ext_e <= 2'h0;
    xfer(ba(`IDX_P3_PULLUP), 1'b1, 32'h3);
    @(negedge hclk);
    chk(pue, 32'h2);
    // timer, then correction clock, take the pins over the latch
    xfer(ba(`IDX_ALT_CTRL), 1'b1, 32'h2);
    tmr <= 1'b1;
    xfer(ba(`DIR_IDX_P3), 1'b1, 32'hFC);
    @(negedge hclk);
    chk(pout, 32'h3);
    xfer(ba(`IDX_P3_DATA), 1'b1, 32'h0);
    rclk <= 1'b1;
    xfer(ba(`IDX_ALT_CTRL), 1'b1, 32'h6);
    @(negedge hclk);
    chk(pout, 32'h3);
    xfer(ba(`IDX_ALT_CTRL), 1'b1, 32'h0);
    @(negedge hclk);
    chk(pout, 32'h0);
    $display("pin test done");
    @(posedge hclk);
    hresetn <= 1'b0;
    @(negedge hclk);
    chk({poe, pue}, 32'h0);
    @(posedge hclk);
    hresetn <= 1'b1;
    rdc(`DIR_IDX_P3, 8'hFF);
    $display("second reset test done");
    summarize();
  end
endmodule
